/* core/bfp_pkg.sv */
// constants and types shared by the boot flash protection block
package bfp_pkg;

  // ******************************
  // geometry defaults
  // ******************************
  localparam int BFP_ADDR_W     = 14;   // program word address bits
  localparam int BFP_PAGE_BITS  = 6;    // word-in-page field width
  localparam int BFP_BOOT_MIN   = 256;  // smallest boot section, words

  // ******************************
  // register byte offsets
  // ******************************
  localparam logic [7:0] BFP_OFF_PTR_LO = 8'h00;
  localparam logic [7:0] BFP_OFF_PTR_HI = 8'h04;
  localparam logic [7:0] BFP_OFF_CTRL   = 8'h08;
  localparam logic [7:0] BFP_OFF_STATUS = 8'h0c;
  localparam logic [7:0] BFP_OFF_OPADDR = 8'h10;

  // ******************************
  // field positions
  // ******************************
  localparam int BFP_CTRL_IVSEL  = 0;   // vectors sit in boot section
  localparam int BFP_LK_APP_LO   = 0;   // lock byte and status share these
  localparam int BFP_LK_APP_HI   = 1;
  localparam int BFP_LK_BOOT_LO  = 2;
  localparam int BFP_LK_BOOT_HI  = 3;
  localparam int BFP_LK_GEN_LSB  = 4;   // general lock pair, bits 5:4
  localparam int BFP_ST_PGM_REJ  = 8;   // sticky: store from app section
  localparam int BFP_ST_WR_BLK   = 9;   // sticky: write blocked by lock
  localparam int BFP_ST_RD_BLK   = 10;  // sticky: read blocked by lock
  localparam int BFP_ST_RSTFUSE  = 11;  // boot reset fuse level
  localparam int BFP_ST_IRQ_DIS  = 12;  // interrupts held off now

  // ******************************
  // reset values
  // ******************************
  localparam logic [5:0] BFP_LOCK_RST = 6'h3f;  // all unprogrammed
  localparam logic [7:0] BFP_PTR_RST  = 8'h00;
  localparam logic       BFP_CTRL_RST = 1'b0;

  // ******************************
  // bus answers and store operations
  // ******************************
  localparam logic [1:0] BFP_RESP_OKAY   = 2'b00;
  localparam logic [1:0] BFP_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    BFP_OP_FILL    = 2'b00,
    BFP_OP_ERASE   = 2'b01,
    BFP_OP_WRITE   = 2'b10,
    BFP_OP_LOCKSET = 2'b11
  } bfp_pgm_op_t;

endpackage

/* core/bfp_core.sv */
// boot flash protection: lock fields, section checks, pointer and op latch
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

// Behaviour
// [R1] two independent lock pairs, application and boot
// [R2] locks only programmed; chip erase restores them
// [R3] general write lock ignored by store operations
// [R4] general read/write lock ignored by load/store
// [R5] app 11 free; app 10 blocks writes
// [R6] app 00 blocks writes and boot-side reads
// [R7] app 01 blocks only boot-side reads
// [R8] app read lock gates interrupts in app
// [R9] boot 11 free; boot 10 blocks writes
// [R10] boot 00 blocks writes and app-side reads
// [R11] boot 01 blocks only app-side reads
// [R12] boot read lock gates interrupts in boot
// [R13] reset fuse selects vector zero or boot
// [R14] processor cannot change any fuse
// [R15] operations addressed by sixteen-bit pointer register
// [R16] word address split into page, word fields
// [R17] software uses same page for erase, write
// [R18] target address latched when operation starts
// [R19] lock setting ignores pointer contents
// [R20] loads address bytes using pointer bit zero
// [R21] store accepted only from boot section
// [R22] section boundary follows boot size fuse
// [R23] page/word split is a design parameter
// [R24] blocked accesses suppressed, flash left unchanged
module bfp_core
  import bfp_pkg::*;
#(
  parameter int ADDR_W    = BFP_ADDR_W,
  parameter int PAGE_BITS = BFP_PAGE_BITS,
  parameter int BOOT_MIN  = BFP_BOOT_MIN
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // core side
  input  wire logic [ADDR_W-1:0] exec_pc,
  input  wire logic              pgm_req,
  input  wire bfp_pgm_op_t       pgm_op,
  input  wire logic [7:0]        pgm_data,
  input  wire logic              lpm_req,
  // fuses and programming interface
  input  wire logic              boot_reset_select_fuse,
  input  wire logic [1:0]        boot_size_fuse,
  input  wire logic              chip_erase,
  input  wire logic              isp_lock_wr,
  input  wire logic [5:0]        isp_lock_data,
  // results
  output logic                   flash_op_start,
  output bfp_pgm_op_t            flash_op_code,
  output logic [ADDR_W-PAGE_BITS-1:0] page_select_field,
  output logic [PAGE_BITS-1:0]   word_in_page_field,
  output logic                   pgm_reject,
  output logic                   pgm_wr_block,
  output logic                   lpm_valid,
  output logic                   lpm_deny,
  output logic [ADDR_W:0]        lpm_addr,
  output logic [5:0]             lock_bits,
  output logic                   irq_disable,
  output logic [ADDR_W-1:0]      reset_vector
);

  localparam logic [ADDR_W:0] FLASH_WORDS = (ADDR_W+1)'(1) << ADDR_W;

  // ******************************
  // section decode
  // ******************************

  // boot start moves with the size fuse: 11 smallest, 00 largest
  function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] sz);
    logic [ADDR_W:0] span;
    span = (ADDR_W+1)'(BOOT_MIN) << (2'd3 - sz);
    return ADDR_W'(FLASH_WORDS - span);
  endfunction

  function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
    return a >= boot_start(sz);
  endfunction

  logic [7:0]        pointer_low_byte_r;
  logic [7:0]        pointer_high_byte_r;
  logic              ivsel_r;
  logic [5:0]        lock_r;
  logic [2:0]        sticky_r;
  logic [15:0]       pointer;
  logic [ADDR_W-1:0] tgt_word;
  logic              exec_boot;
  logic              tgt_boot;
  logic              app_lock_lo;
  logic              app_lock_hi;
  logic              boot_lock_lo;
  logic              boot_lock_hi;
  logic [1:0]        app_lock_field;
  logic [1:0]        boot_lock_field;

  // pointer and section of the instruction and of its target
  assign pointer         = {pointer_high_byte_r, pointer_low_byte_r};   // see [R15]
  assign tgt_word        = pointer[ADDR_W:1];
  assign exec_boot       = in_boot(exec_pc, boot_size_fuse);             // see [R22]
  assign tgt_boot        = in_boot(tgt_word, boot_size_fuse);            // see [R24]
  assign app_lock_lo     = lock_r[BFP_LK_APP_LO];
  assign app_lock_hi     = lock_r[BFP_LK_APP_HI];
  assign boot_lock_lo    = lock_r[BFP_LK_BOOT_LO];
  assign boot_lock_hi    = lock_r[BFP_LK_BOOT_HI];
  assign app_lock_field  = {app_lock_hi, app_lock_lo};
  assign boot_lock_field = {boot_lock_hi, boot_lock_lo};

  // ******************************
  // store and load checks
  // ******************************
  logic pgm_fire;
  logic pgm_from_app;
  logic is_prog;
  logic wr_locked;
  logic op_take;
  logic lock_take;
  logic wr_blk_ev;
  logic rd_blk;
  logic lpm_fire;

  // a low lock bit blocks writes; general lock pair is not consulted
  assign pgm_fire     = clk_en & pgm_req;
  assign pgm_from_app = !exec_boot;                                      // see [R21]
  assign is_prog      = (pgm_op == BFP_OP_ERASE) | (pgm_op == BFP_OP_WRITE);
  assign wr_locked    = tgt_boot ? !boot_lock_lo : !app_lock_lo;         // see [R3] see [R5] see [R9]
  assign op_take      = pgm_fire & exec_boot & ((pgm_op == BFP_OP_FILL) | (is_prog & !wr_locked));
  assign lock_take    = pgm_fire & exec_boot & (pgm_op == BFP_OP_LOCKSET); // see [R19]
  assign wr_blk_ev    = pgm_fire & exec_boot & is_prog & wr_locked;      // see [R24]

  // cross-section reads blocked by the high lock bit of the target
  assign lpm_fire = clk_en & lpm_req;
  assign rd_blk   = (tgt_boot & !exec_boot & !boot_lock_hi)              // see [R10] see [R11]
                  | (!tgt_boot & exec_boot & !app_lock_hi);              // see [R6] see [R7] see [R4]

  // ******************************
  // lock bits
  // ******************************

  // bits only fall; chip erase raises all, a same-cycle program still wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= BFP_LOCK_RST;
    end else if (clk_en) begin
      lock_r <= (chip_erase ? BFP_LOCK_RST : lock_r)                     // see [R2]
              & (isp_lock_wr ? isp_lock_data : BFP_LOCK_RST)
              & (lock_take ? pgm_data[5:0] : BFP_LOCK_RST);              // see [R1]
    end
  end

  // ******************************
  // operation latch
  // ******************************

  // target fields frozen at start, pointer free afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_op_start     <= 1'b0;
      flash_op_code      <= BFP_OP_FILL;
      page_select_field  <= '0;
      word_in_page_field <= '0;
    end else if (clk_en) begin
      flash_op_start <= op_take;
      if (op_take) begin
        flash_op_code      <= pgm_op;
        page_select_field  <= tgt_word[ADDR_W-1:PAGE_BITS];              // see [R16] see [R23]
        word_in_page_field <= tgt_word[PAGE_BITS-1:0];                   // see [R18]
      end
    end
  end

  // reject pulses for the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pgm_reject   <= 1'b0;
      pgm_wr_block <= 1'b0;
    end else if (clk_en) begin
      pgm_reject   <= pgm_req & pgm_from_app;                            // see [R21]
      pgm_wr_block <= wr_blk_ev;
    end
  end

  // load result: byte address or deny
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpm_valid <= 1'b0;
      lpm_deny  <= 1'b0;
      lpm_addr  <= '0;
    end else if (clk_en) begin
      lpm_valid <= lpm_req & !rd_blk;
      lpm_deny  <= lpm_req & rd_blk;
      if (lpm_req & !rd_blk) begin
        lpm_addr <= pointer[ADDR_W:0];                                   // see [R20]
      end
    end
  end

  // ******************************
  // interrupt gate and reset vector
  // ******************************

  // fuses are inputs only; nothing here can write them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_disable  <= 1'b0;
      reset_vector <= '0;
    end else if (clk_en) begin
      irq_disable  <= (!exec_boot & !app_lock_hi & ivsel_r)              // see [R8]
                    | (exec_boot & !boot_lock_hi & !ivsel_r);            // see [R12]
      reset_vector <= boot_reset_select_fuse ? '0 : boot_start(boot_size_fuse); // see [R13] see [R14]
    end
  end

  assign lock_bits = lock_r;

  // ******************************
  // axi4-lite write channel
  // ******************************
  logic       aw_held_r;
  logic [7:0] awaddr_r;
  logic       w_held_r;
  logic [7:0] wbyte_r;
  logic [2:0] wlow_r;
  logic       wstrb0_r;
  logic       do_wr;
  logic       wr_hit;

  assign s_axi_awready = clk_en & !aw_held_r & !s_axi_bvalid;
  assign s_axi_wready  = clk_en & !w_held_r & !s_axi_bvalid;
  assign do_wr         = clk_en & aw_held_r & w_held_r & !s_axi_bvalid;
  assign wr_hit        = (awaddr_r == BFP_OFF_PTR_LO) | (awaddr_r == BFP_OFF_PTR_HI)
                       | (awaddr_r == BFP_OFF_CTRL) | (awaddr_r == BFP_OFF_STATUS);

  // address and data taken in either order, answer once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      awaddr_r     <= '0;
      w_held_r     <= 1'b0;
      wbyte_r      <= '0;
      wlow_r       <= '0;
      wstrb0_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BFP_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wbyte_r  <= s_axi_wdata[7:0];
        wlow_r   <= {s_axi_wdata[BFP_ST_RD_BLK], s_axi_wdata[BFP_ST_WR_BLK], s_axi_wdata[BFP_ST_PGM_REJ]};
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? BFP_RESP_OKAY : BFP_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // pointer bytes and control bit under byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pointer_low_byte_r  <= BFP_PTR_RST;
      pointer_high_byte_r <= BFP_PTR_RST;
      ivsel_r             <= BFP_CTRL_RST;
    end else if (do_wr & wstrb0_r) begin
      if (awaddr_r == BFP_OFF_PTR_LO) pointer_low_byte_r <= wbyte_r;
      if (awaddr_r == BFP_OFF_PTR_HI) pointer_high_byte_r <= wbyte_r;
      if (awaddr_r == BFP_OFF_CTRL)   ivsel_r <= wbyte_r[BFP_CTRL_IVSEL];
    end
  end

  // sticky event flags, write one clears, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky_r <= '0;
    end else if (clk_en) begin
      sticky_r <= (sticky_r & ~((do_wr & (awaddr_r == BFP_OFF_STATUS)) ? wlow_r : 3'h0))
                | {lpm_fire & rd_blk, wr_blk_ev, pgm_fire & pgm_from_app};
    end
  end

  // ******************************
  // axi4-lite read channel
  // ******************************
  logic [31:0] rd_word;
  logic        rd_hit;

  // read mux; unmapped offsets give zero and slverr
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      BFP_OFF_PTR_LO: rd_word[7:0] = pointer_low_byte_r;
      BFP_OFF_PTR_HI: rd_word[7:0] = pointer_high_byte_r;
      BFP_OFF_CTRL:   rd_word[BFP_CTRL_IVSEL] = ivsel_r;
      BFP_OFF_STATUS: begin
        rd_word[5:0]                           = lock_r;
        rd_word[BFP_ST_RD_BLK:BFP_ST_PGM_REJ]  = sticky_r;
        rd_word[BFP_ST_RSTFUSE]                = boot_reset_select_fuse;
        rd_word[BFP_ST_IRQ_DIS]                = irq_disable;
      end
      BFP_OFF_OPADDR: rd_word[ADDR_W-1:0] = {page_select_field, word_in_page_field};
      default:        rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = clk_en & !s_axi_rvalid;

  // one read in flight, answered the edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= BFP_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? BFP_RESP_OKAY : BFP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ******************************
  // checks
  // ******************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pgm_from_app_a: assert property (pgm_fire & pgm_from_app |=> pgm_reject & !flash_op_start) // see [R21]
    else $error("store from application section was not refused");

  app_wr_lock_a: assert property (pgm_fire & exec_boot & is_prog & !tgt_boot & !app_lock_lo // see [R5]
    |=> !flash_op_start & pgm_wr_block)
    else $error("write to locked application section went ahead");

  boot_wr_lock_a: assert property (pgm_fire & exec_boot & is_prog & tgt_boot & !boot_lock_lo // see [R9]
    |=> !flash_op_start & pgm_wr_block)
    else $error("write to locked boot section went ahead");

  app_wr_open_a: assert property (pgm_fire & exec_boot & is_prog & !tgt_boot & app_lock_lo // see [R7]
    |=> flash_op_start & (flash_op_code == $past(pgm_op)))
    else $error("permitted application write was not started");

  app_rd_lock_a: assert property (lpm_fire & exec_boot & !tgt_boot & !app_lock_hi // see [R6]
    |=> lpm_deny & !lpm_valid)
    else $error("boot-side read of locked application section allowed");

  boot_rd_lock_a: assert property (lpm_fire & !exec_boot & tgt_boot & !boot_lock_hi // see [R10]
    |=> lpm_deny & !lpm_valid)
    else $error("application-side read of locked boot section allowed");

  lpm_byte_a: assert property (lpm_fire & !rd_blk |=> lpm_valid & (lpm_addr == $past(pointer[ADDR_W:0]))) // see [R20]
    else $error("load byte address does not match pointer");

  op_latch_a: assert property (!op_take ##1 !op_take // see [R18]
    |-> $stable(page_select_field) & $stable(word_in_page_field))
    else $error("latched operation address moved without a new operation");

  lock_fall_a: assert property (clk_en & !chip_erase |=> (lock_r & ~$past(lock_r)) == 6'h00) // see [R2]
    else $error("lock bit returned to unprogrammed without chip erase");

  irq_gate_a: assert property (clk_en & !exec_boot & !app_lock_hi & ivsel_r |=> irq_disable) // see [R8]
    else $error("interrupts not held off in read-locked application section");

  rst_vec_a: assert property (clk_en & !boot_reset_select_fuse |=> reset_vector == boot_start($past(boot_size_fuse))) // see [R13]
    else $error("reset vector does not follow boot reset fuse");

endmodule

/* dv/bfp_cpu_model.sv */
// processor core model issuing store and load program requests
`timescale 1ns/10ps
module bfp_cpu_model
  import bfp_pkg::*;
(
  input  wire logic   aclk,
  output logic [13:0] exec_pc,
  output logic        pgm_req,
  output bfp_pgm_op_t pgm_op,
  output logic [7:0]  pgm_data,
  output logic        lpm_req
);
  // quiet core at time zero
  initial begin
    exec_pc = 14'h0000;
    pgm_req = 1'h0;
    pgm_op = BFP_OP_FILL;
    pgm_data = 8'h5a;
    lpm_req = 1'h0;
  end

  // move execution to another word address
  task automatic run_at(input logic [13:0] pc);
    @(posedge aclk);
    exec_pc <= pc;
  endtask

  // one store instruction; qualifiers go stale once it is taken
  task automatic store(input logic [13:0] pc, input bfp_pgm_op_t op, input logic [7:0] d);
    @(posedge aclk);
    exec_pc <= pc;
    pgm_req <= 1'h1;
    pgm_op <= op;
    pgm_data <= d;
    @(posedge aclk);
    pgm_req <= 1'h0;
    pgm_op <= bfp_pgm_op_t'(~op);
    pgm_data <= ~d;
  endtask

  // one load instruction
  task automatic load(input logic [13:0] pc);
    @(posedge aclk);
    exec_pc <= pc;
    lpm_req <= 1'h1;
    @(posedge aclk);
    lpm_req <= 1'h0;
  endtask
endmodule

/* dv/boot_flash_protection_tb_top.sv */
// self-checking bench for the boot flash protection block
`timescale 1ns/10ps
module boot_flash_protection_tb_top;
  import bfp_pkg::*;

  // ******************************
  // signals and table
  // ******************************
  typedef struct packed {
    logic [3:0] lk;   // boot hi, boot lo, app hi, app lo
    logic       pcb;  // instruction runs in boot section
    logic       tgb;  // target in boot section
    logic       ld;   // load instead of erase
    logic [2:0] res;  // start/block/reject or valid/deny/0
  } bfp_row_t;
  localparam logic [13:0] PC_BOOT = 14'h3f10;
  localparam logic [13:0] PC_APP  = 14'h0100;
  logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pgm_data, page_select_field;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, boot_size_fuse;
  logic [13:0] exec_pc, reset_vector;
  logic        pgm_req, lpm_req, boot_reset_select_fuse, chip_erase, isp_lock_wr;
  logic        flash_op_start, pgm_reject, pgm_wr_block, lpm_valid, lpm_deny, irq_disable;
  logic [5:0]  isp_lock_data, word_in_page_field, lock_bits;
  logic [14:0] lpm_addr;
  bfp_pgm_op_t pgm_op, flash_op_code;
  logic [2:0]  got;
  int          fail_count, tests_run;
  bfp_row_t rows [15] = '{
    '{4'hf, 1'h1, 1'h0, 1'h0, 3'h4},
    '{4'he, 1'h1, 1'h0, 1'h0, 3'h2},
    '{4'he, 1'h1, 1'h0, 1'h1, 3'h4},
    '{4'hc, 1'h1, 1'h0, 1'h0, 3'h2},
    '{4'hc, 1'h1, 1'h0, 1'h1, 3'h2},
    '{4'hd, 1'h1, 1'h0, 1'h0, 3'h4},
    '{4'hd, 1'h1, 1'h0, 1'h1, 3'h2},
    '{4'hb, 1'h1, 1'h1, 1'h0, 3'h2},
    '{4'hf, 1'h0, 1'h1, 1'h1, 3'h4},
    '{4'h3, 1'h1, 1'h1, 1'h0, 3'h2},
    '{4'h3, 1'h0, 1'h1, 1'h1, 3'h2},
    '{4'h3, 1'h1, 1'h1, 1'h1, 3'h4},
    '{4'h7, 1'h1, 1'h1, 1'h0, 3'h4},
    '{4'h7, 1'h0, 1'h1, 1'h1, 3'h2},
    '{4'hf, 1'h0, 1'h0, 1'h0, 3'h1}
  };

  bfp_core dut_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_pc,
    .pgm_req, .pgm_op, .pgm_data, .lpm_req, .boot_reset_select_fuse, .boot_size_fuse, .chip_erase,
    .isp_lock_wr, .isp_lock_data, .flash_op_start, .flash_op_code, .page_select_field, .word_in_page_field,
    .pgm_reject, .pgm_wr_block, .lpm_valid, .lpm_deny, .lpm_addr, .lock_bits, .irq_disable, .reset_vector);
  bfp_cpu_model cpu_u (.aclk, .exec_pc, .pgm_req, .pgm_op, .pgm_data, .lpm_req);

  // ******************************
  // tasks
  // ******************************
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // write one word; readies looked at mid-cycle, released after the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!v) begin
      @(negedge aclk);
      t = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    chk("rdata", ed, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  task automatic set_ptr(input logic [15:0] p);
    axi_wr(BFP_OFF_PTR_LO, {24'h0, p[7:0]}, BFP_RESP_OKAY);
    axi_wr(BFP_OFF_PTR_HI, {24'h0, p[15:8]}, BFP_RESP_OKAY);
  endtask

  // optional chip erase, then programming-interface lock write
  task automatic lock_prog(input logic er, input logic [5:0] v);
    @(posedge aclk);
    chip_erase <= er;
    @(posedge aclk);
    chip_erase <= 1'h0;
    isp_lock_wr <= 1'h1;
    isp_lock_data <= v;
    @(posedge aclk);
    isp_lock_wr <= 1'h0;
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // ******************************
  // clock, watchdog, main sequence
  // ******************************
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    test_done();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {chip_erase, isp_lock_wr, isp_lock_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {clk_en, boot_reset_select_fuse, boot_size_fuse, s_axi_wstrb} = 8'hff;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    settle();
    chk("lock_bits", 32'(BFP_LOCK_RST), 32'(lock_bits));
    chk("reset_vector", 32'h0, 32'(reset_vector));
    // table of lock modes; general pair programmed in every row
    foreach (rows[i]) begin
      lock_prog(1'h1, {2'h0, rows[i].lk});
      chk("lock_bits", 32'({2'h0, rows[i].lk}), 32'(lock_bits));
      set_ptr(rows[i].tgb ? 16'h7e80 : 16'h0a42);
      if (rows[i].ld) cpu_u.load(rows[i].pcb ? PC_BOOT : PC_APP);
      else cpu_u.store(rows[i].pcb ? PC_BOOT : PC_APP, BFP_OP_ERASE, 8'hff);
      #1;
      got = rows[i].ld ? {lpm_valid, lpm_deny, 1'h0} : {flash_op_start, pgm_wr_block, pgm_reject};
      chk("result", 32'(rows[i].res), 32'(got));
    end
    // programming cannot undo a lock, only erase can
    lock_prog(1'h0, 6'h3f);
    chk("lock_bits", 32'h0f, 32'(lock_bits));
    lock_prog(1'h1, 6'h3f);
    chk("lock_bits", 32'h3f, 32'(lock_bits));
    // erase latches target; pointer moved afterwards
    set_ptr(16'h0a42);
    cpu_u.store(PC_BOOT, BFP_OP_ERASE, 8'hff);
    set_ptr(16'h7e80);
    chk("target", 32'h521, 32'({page_select_field, word_in_page_field}));
    // lock set from boot section with unrelated pointer
    cpu_u.store(PC_BOOT, BFP_OP_LOCKSET, 8'hf3);
    #1;
    chk("op_start", 32'h0, 32'(flash_op_start));
    chk("lock_bits", 32'h33, 32'(lock_bits));
    chk("target", 32'h521, 32'({page_select_field, word_in_page_field}));
    set_ptr(16'h0a42);
    cpu_u.store(PC_BOOT, BFP_OP_WRITE, 8'hff);
    #1;
    chk("write", 32'h18521, 32'({flash_op_start, flash_op_code, page_select_field, word_in_page_field}));
    axi_rd(BFP_OFF_OPADDR, 32'h521, BFP_RESP_OKAY);
    // byte-wise load address with odd pointer
    set_ptr(16'h0a43);
    cpu_u.load(PC_APP);
    #1;
    chk("lpm_addr", 32'h0a43, 32'(lpm_addr));
    axi_rd(BFP_OFF_PTR_LO, 32'h43, BFP_RESP_OKAY);
    axi_wr(8'h40, 32'h1, BFP_RESP_SLVERR);
    axi_rd(8'h40, 32'h0, BFP_RESP_SLVERR);
    // sticky refusal flags seen by the table, then cleared by writing ones
    axi_rd(BFP_OFF_STATUS, 32'hf33, BFP_RESP_OKAY);
    axi_wr(BFP_OFF_STATUS, 32'h700, BFP_RESP_OKAY);
    axi_rd(BFP_OFF_STATUS, 32'h833, BFP_RESP_OKAY);
    // interrupt hold-off, boot read lock with vectors in application, then application read lock with vectors in boot
    axi_wr(BFP_OFF_CTRL, 32'h0, BFP_RESP_OKAY);
    cpu_u.run_at(PC_BOOT);
    settle();
    chk("irq_disable", 32'h1, 32'(irq_disable));
    cpu_u.run_at(PC_APP);
    settle();
    chk("irq_disable", 32'h0, 32'(irq_disable));
    lock_prog(1'h1, 6'h3d);
    axi_wr(BFP_OFF_CTRL, 32'h1, BFP_RESP_OKAY);
    settle();
    chk("irq_disable", 32'h1, 32'(irq_disable));
    cpu_u.run_at(PC_BOOT);
    settle();
    chk("irq_disable", 32'h0, 32'(irq_disable));
    // reset vector follows fuses
    @(posedge aclk);
    boot_reset_select_fuse <= 1'h0;
    settle();
    chk("reset_vector", 32'h3f00, 32'(reset_vector));
    @(posedge aclk);
    boot_size_fuse <= 2'h0;
    settle();
    chk("reset_vector", 32'h3800, 32'(reset_vector));
    test_done();
  end
endmodule
